//--- verilog/dlc_global_cfg.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Per link, standard bit 0 selects E1, 1 selects NORTH_AMERICAN_OR_JAPANESE_VARIANT.
// - In NORTH_AMERICAN_OR_JAPANESE_VARIANT, variant bit 0 is T1, 1 is J1; ignored in E1.
// - Framing field 00 SF, 01 ESF, 10 DM, 11 SLC-96 in NORTH_AMERICAN_OR_JAPANESE_VARIANT.
// - DM and SLC-96 only valid for T1; flagged if programmed under J1.
// - Single-address registers are global; paired ones are per link.
// - Fixed read-only 8-bit identity: part nibble high, revision low.
// - Any write to the reset register triggers software reset while the oscillator is present.
// - Software reset restores defaults except the mode registers.
// - Monitor code 01 watches link 2 receiver, 11 link 2 transmitter.
// - Monitor bit0 low means no path is monitored.
module dlc_global_cfg (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [dlc_pkg::DLC_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Oscillator presence
    input wire logic osc_present_i,
    // Link configuration and software reset pulse
    output dlc_pkg::dlc_link_cfg_t link1_cfg_o,
    output dlc_pkg::dlc_link_cfg_t link2_cfg_o,
    output logic sw_reset_o,
    // Monitor path of link 2
    output dlc_pkg::dlc_mon_t monitor_path_o
);
    import dlc_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [11:0] idx;
    logic word_ok;
    logic hit_id;
    logic hit_rst;
    logic hit_mon;
    logic hit_m1;
    logic hit_m2;
    logic mapped;
    logic setup;
    logic wr_go;
    logic [31:0] rdata_d;
    // Write strobes and write data fields
    logic wr_mode1;
    logic wr_mode2;
    logic wr_mon;
    logic wr_rst;
    logic swrst_req;
    logic [3:0] wd_mode;
    logic [1:0] wd_mon;
    // Error terms
    logic addr_bad;
    logic wr_to_ro;
    logic rd_of_wo;
    logic err_d;
    // Read words and their one-hot select
    logic [31:0] rd_id_w;
    logic [31:0] rd_mon_w;
    logic [31:0] rd_m1_w;
    logic [31:0] rd_m2_w;
    logic [3:0] rd_sel;

    // Word index from byte address
    assign idx = paddr_i[DLC_ADDR_W-1:2];
    assign word_ok = (paddr_i[1:0] == 2'h0);
    assign hit_id = word_ok && (idx == DLC_IDX_DEVICE_ID);
    assign hit_rst = word_ok && (idx == DLC_IDX_SW_RESET);
    assign hit_mon = word_ok && (idx == DLC_IDX_MONITOR);
    assign hit_m1 = word_ok && (idx == DLC_IDX_MODE_L1);
    assign hit_m2 = word_ok && (idx == DLC_IDX_MODE_L2);
    assign mapped = hit_id | hit_rst | hit_mon | hit_m1 | hit_m2;
    assign setup = psel_i && !penable_i;
    // Write commits in the access cycle with pready high
    assign wr_go = psel_i && penable_i && pready_o && pwrite_i && mapped;

    // ------------------------------------------------------------
    // Write strobes and write data fields
    // ------------------------------------------------------------
    // One strobe per writable register, none for the identity, all on the commit edge
    assign wr_mode1 = wr_go && hit_m1;
    assign wr_mode2 = wr_go && hit_m2;
    assign wr_mon = wr_go && hit_mon;
    assign wr_rst = wr_go && hit_rst;
    // Reset request is dropped while the oscillator is absent
    assign swrst_req = wr_rst && osc_present_i;
    // Only the defined bits are kept
    assign wd_mode = pwdata_i[3:0];
    assign wd_mon = {pwdata_i[DLC_MON_TX_BIT], pwdata_i[DLC_MON_EN_BIT]};

    // ------------------------------------------------------------
    // Error decode
    // ------------------------------------------------------------
    // Unmapped or misaligned, write to identity, read of trigger
    assign addr_bad = !mapped;
    assign wr_to_ro = pwrite_i && hit_id;
    assign rd_of_wo = !pwrite_i && hit_rst;
    assign err_d = addr_bad || wr_to_ro || rd_of_wo;

    // ------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_SETUP = 3'b010,
        PH_ACCESS = 3'b100
    } dlc_phase_t;

    dlc_phase_t phase_q;
    dlc_phase_t phase_d;

    // Phase seen at each edge; an access with no setup gets no answer
    always_comb begin
        phase_d = PH_IDLE;
        case (phase_q)
            PH_IDLE: begin
                if (setup) begin
                    phase_d = PH_SETUP;
                end
            end
            PH_SETUP: begin
                if (psel_i && penable_i) begin
                    phase_d = PH_ACCESS;
                end else if (setup) begin
                    phase_d = PH_SETUP;
                end
            end
            PH_ACCESS: begin
                if (setup) begin
                    phase_d = PH_SETUP;
                end else if (psel_i && penable_i) begin
                    phase_d = PH_ACCESS;
                end
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0] mode1_q;
    logic [3:0] mode2_q;
    logic [1:0] mon_q;
    logic swrst_q;

    // Link 1 mode, untouched by software reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode1_q <= DLC_MODE_RESET;
        end else if (wr_mode1) begin
            mode1_q <= wd_mode;
        end
    end

    // Link 2 mode, untouched by software reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode2_q <= DLC_MODE_RESET;
        end else if (wr_mode2) begin
            mode2_q <= wd_mode;
        end
    end

    // ------------------------------------------------------------
    // Software reset
    // ------------------------------------------------------------
    // One-cycle pulse on a write to the trigger while the oscillator is present, data ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= swrst_req;
        end
    end

    // ------------------------------------------------------------
    // Monitor select
    // ------------------------------------------------------------
    // Cleared by either reset; the clear beats a write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || swrst_q) begin
            mon_q <= DLC_MON_RESET;
        end else if (wr_mon) begin
            mon_q <= wd_mon;
        end
    end

    // ------------------------------------------------------------
    // Monitor path output
    // ------------------------------------------------------------
    dlc_mon_t mon_path_d;

    // Bit 0 enables monitoring, bit 3 picks transmitter over receiver
    always_comb begin
        mon_path_d = DLC_MON_NONE;
        case (mon_q)
            2'b01: begin
                mon_path_d = DLC_MON_RX2;
            end
            2'b11: begin
                mon_path_d = DLC_MON_TX2;
            end
            2'b00: begin
                mon_path_d = DLC_MON_NONE;
            end
            2'b10: begin
                mon_path_d = DLC_MON_NONE;
            end
            default: begin
                mon_path_d = DLC_MON_NONE;
            end
        endcase
    end

    // Registered monitor path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            monitor_path_o <= DLC_MON_NONE;
        end else begin
            monitor_path_o <= mon_path_d;
        end
    end

    // ------------------------------------------------------------
    // Software reset pulse out
    // ------------------------------------------------------------
    // Delayed copy of the internal pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_reset_o <= 1'b0;
        end else begin
            sw_reset_o <= swrst_q;
        end
    end

    // ------------------------------------------------------------
    // Per-link decoders
    // ------------------------------------------------------------
    dlc_link_decode u_link1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode1_q),
        .cfg_o(link1_cfg_o)
    );

    dlc_link_decode u_link2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode2_q),
        .cfg_o(link2_cfg_o)
    );

    // ------------------------------------------------------------
    // APB read and answer
    // ------------------------------------------------------------
    // Per-register read words, reserved bits zero
    assign rd_id_w = {24'h00_0000, DLC_PART_CODE, DLC_REV_CODE};
    assign rd_mon_w = {28'h000_0000, mon_q[1], 2'h0, mon_q[0]};
    assign rd_m1_w = {28'h000_0000, mode1_q};
    assign rd_m2_w = {28'h000_0000, mode2_q};
    // One-hot read select; the trigger reads as zero
    assign rd_sel = {hit_m2, hit_m1, hit_mon, hit_id};

    // Read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (rd_sel)
            4'h1: begin
                rdata_d = rd_id_w;
            end
            4'h2: begin
                rdata_d = rd_mon_w;
            end
            4'h4: begin
                rdata_d = rd_m1_w;
            end
            4'h8: begin
                rdata_d = rd_m2_w;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Ready in the first access cycle, never later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= (phase_d == PH_SETUP);
        end
    end

    // Error flag, judged in the setup cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup && err_d;
        end
    end

    // Read data stands only with ready, zero otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup && !pwrite_i) begin
            prdata_o <= rdata_d;
        end else begin
            prdata_o <= 32'h0000_0000;
        end
    end

endmodule // dlc_global_cfg

`default_nettype wire

//--- pkg/dlc_pkg.sv
package dlc_pkg;

    // ------------------------------------------------------------
    // Register word indices; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [11:0] DLC_IDX_DEVICE_ID = 12'h000;
    localparam logic [11:0] DLC_IDX_SW_RESET = 12'h004;
    localparam logic [11:0] DLC_IDX_MONITOR = 12'h005;
    localparam logic [11:0] DLC_IDX_MODE_L1 = 12'h020;
    localparam logic [11:0] DLC_IDX_MODE_L2 = 12'h120;
    localparam int DLC_ADDR_W = 14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DLC_MODE_STD_BIT = 0;
    localparam int DLC_MODE_FM_LO = 1;
    localparam int DLC_MODE_VAR_BIT = 3;
    localparam int DLC_MON_EN_BIT = 0;
    localparam int DLC_MON_TX_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and identity
    // ------------------------------------------------------------
    localparam logic [3:0] DLC_MODE_RESET = 4'h0;
    localparam logic [1:0] DLC_MON_RESET = 2'h0;
    // Part and revision codes are arbitrary values
    localparam logic [3:0] DLC_PART_CODE = 4'ha;
    localparam logic [3:0] DLC_REV_CODE = 4'h3;

    // ------------------------------------------------------------
    // Decoded per-link mode and monitor path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DLC_STD_E1 = 3'b001,
        DLC_STD_T1 = 3'b010,
        DLC_STD_J1 = 3'b100
    } dlc_std_t;

    typedef enum logic [3:0] {
        DLC_FMT_SF = 4'b0001,
        DLC_FMT_ESF = 4'b0010,
        DLC_FMT_DM = 4'b0100,
        DLC_FMT_SLC = 4'b1000
    } dlc_fmt_t;

    typedef enum logic [2:0] {
        DLC_MON_NONE = 3'b001,
        DLC_MON_RX2 = 3'b010,
        DLC_MON_TX2 = 3'b100
    } dlc_mon_t;

    typedef struct packed {
        dlc_std_t std;
        dlc_fmt_t fmt;
        logic fmt_err;
    } dlc_link_cfg_t;

endpackage

//--- verilog/dlc_link_decode.sv
`timescale 1ns/1ns
`default_nettype none

module dlc_link_decode (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw mode bits
    input wire logic [3:0] mode_i,
    // Decoded configuration
    output dlc_pkg::dlc_link_cfg_t cfg_o
);
    import dlc_pkg::*;

    dlc_std_t std_d;
    dlc_fmt_t fmt_d;
    logic err_d;

    // Standard and format decode
    always_comb begin
        std_d = DLC_STD_E1;
        fmt_d = DLC_FMT_SF;
        err_d = 1'b0;
        if (mode_i[DLC_MODE_STD_BIT]) begin
            std_d = mode_i[DLC_MODE_VAR_BIT] ? DLC_STD_J1 : DLC_STD_T1;
            case (mode_i[DLC_MODE_FM_LO +: 2])
                2'h0: fmt_d = DLC_FMT_SF;
                2'h1: fmt_d = DLC_FMT_ESF;
                2'h2: fmt_d = DLC_FMT_DM;
                2'h3: fmt_d = DLC_FMT_SLC;
                default: fmt_d = DLC_FMT_SF;
            endcase
            // DM and SLC-96 are illegal under J1
            err_d = mode_i[DLC_MODE_VAR_BIT] & mode_i[DLC_MODE_FM_LO + 1];
        end
    end

    // Registered output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '{std: DLC_STD_E1, fmt: DLC_FMT_SF, fmt_err: 1'b0};
        end else begin
            cfg_o <= '{std: std_d, fmt: fmt_d, fmt_err: err_d};
        end
    end

endmodule // dlc_link_decode

`default_nettype wire

//--- sim/dlc_global_cfg_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dlc_global_cfg_monitor import dlc_pkg::*; (
    // Bus and control
    input wire logic clk_i, rst_i, psel_i, penable_i, pwrite_i, osc_present_i,
    input wire logic [DLC_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic pready_o, pslverr_o, sw_reset_o,
    // Decoded outputs
    input wire dlc_link_cfg_t link1_cfg_o, link2_cfg_o,
    input wire dlc_mon_t monitor_path_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Committed write, word index, data fields
    wire logic wr = psel_i && penable_i && pwrite_i && pready_o;
    wire logic [11:0] ix = paddr_i[13:2];
    wire logic [3:0] wd = pwdata_i[3:0];
    wire logic [1:0] wf = pwdata_i[2:1];
    // Bit 0 enables, bit 3 picks the upper code
    function automatic logic [2:0] f(input logic [3:0] d);
        return d[0] ? (d[3] ? 3'h4 : 3'h2) : 3'h1;
    endfunction
    property p_std1;
        wr && ix == DLC_IDX_MODE_L1 |-> ##2 link1_cfg_o.std == f($past(wd, 2));
    endproperty
    a_std1: assert property (p_std1) else $error("link1 standard wrong");
    property p_std2;
        wr && ix == DLC_IDX_MODE_L2 |-> ##2 link2_cfg_o.std == f($past(wd, 2));
    endproperty
    a_std2: assert property (p_std2) else $error("link2 standard wrong");
    property p_fmt;
        wr && ix == DLC_IDX_MODE_L1 && wd[0] |-> ##2 link1_cfg_o.fmt == 4'h1 << $past(wf, 2);
    endproperty
    a_fmt: assert property (p_fmt) else $error("link1 format wrong");
    property p_err;
        link1_cfg_o.fmt_err == (link1_cfg_o.std == DLC_STD_J1 && link1_cfg_o.fmt[3:2] != 2'h0);
    endproperty
    a_err: assert property (p_err) else $error("format flag wrong");
    property p_id;
        psel_i && pready_o && !pwrite_i && paddr_i == 14'h0 |->
            prdata_o == {24'h0, DLC_PART_CODE, DLC_REV_CODE};
    endproperty
    a_id: assert property (p_id) else $error("identity read wrong");
    property p_swr;
        wr && ix == DLC_IDX_SW_RESET |-> ##2 sw_reset_o == $past(osc_present_i, 2);
    endproperty
    a_swr: assert property (p_swr) else $error("reset pulse wrong");
    property p_clr;
        sw_reset_o |=> monitor_path_o == DLC_MON_NONE;
    endproperty
    a_clr: assert property (p_clr) else $error("monitor not cleared");
    property p_mon;
        wr && ix == DLC_IDX_MONITOR |-> ##2 monitor_path_o == f($past(wd, 2));
    endproperty
    a_mon: assert property (p_mon) else $error("monitor path wrong");
    c_swr: cover property (sw_reset_o);
    c_tx: cover property (monitor_path_o == DLC_MON_TX2);
    c_err: cover property (link1_cfg_o.fmt_err);
endmodule // dlc_global_cfg_monitor
bind dlc_global_cfg dlc_global_cfg_monitor dlc_global_cfg_monitor_i (.clk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .osc_present_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .sw_reset_o, .link1_cfg_o, .link2_cfg_o, .monitor_path_o);
`default_nettype wire

//--- sim/tb_dlc_global_cfg.sv
`timescale 1ns/1ns
`default_nettype none
module tb_dlc_global_cfg;
    import dlc_pkg::*;
    logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, osc_present_i = 1;
    logic [13:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic pready_o, pslverr_o, sw_reset_o, er;
    dlc_link_cfg_t link1_cfg_o, link2_cfg_o;
    dlc_mon_t monitor_path_o;
    int num_errors = 0, comparisons = 0;
    always #2 clk_i = ~clk_i;
    dlc_global_cfg dlc_global_cfg_i (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .osc_present_i,
        .link1_cfg_o, .link2_cfg_o, .sw_reset_o, .monitor_path_o);
    task finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    // One bus transfer, held until ready is seen
    task apb(input logic w, input logic [11:0] ix, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= {ix, 2'h0};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do begin
            @(posedge clk_i);
            i++;
        end while (pready_o !== 1'b1 && i < 20);
        if (i >= 20 && pready_o !== 1'b1) begin
            num_errors++;
            finish_test;
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    // Expected decoded link word
    function logic [7:0] ecfg(input logic [3:0] m);
        return {m[0] ? (m[3] ? 3'h4 : 3'h2) : 3'h1, m[0] ? 4'h1 << m[2:1] : 4'h1, m[0] & m[3] & m[2]};
    endfunction
    task t_reset;
        chk("cfg1", ecfg(4'h0), link1_cfg_o);
        chk("path", DLC_MON_NONE, monitor_path_o);
        apb(0, DLC_IDX_DEVICE_ID, 0);
        chk("id", {DLC_PART_CODE, DLC_REV_CODE}, rd);
        apb(1, DLC_IDX_DEVICE_ID, 32'hff);
        chk("id_err", 1, er);
        apb(0, DLC_IDX_DEVICE_ID, 0);
        chk("id_kept", {DLC_PART_CODE, DLC_REV_CODE}, rd);
        apb(0, 12'h002, 0);
        chk("unmapped", 1, er);
        apb(0, DLC_IDX_SW_RESET, 0);
        chk("rst_rd_err", 1, er);
        chk("rst_rd", 0, rd);
        apb(0, DLC_IDX_MONITOR, 0);
        chk("mon_rst", 0, rd);
    endtask
    // Hardware reset in mid-run returns mode and monitor to defaults
    task t_hwrst;
        apb(1, DLC_IDX_MONITOR, 32'h1);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("hw_path", DLC_MON_NONE, monitor_path_o);
        chk("hw_cfg", ecfg(4'h0), link1_cfg_o);
        apb(0, DLC_IDX_MODE_L1, 0);
        chk("hw_mode", 0, rd);
    endtask
    // All mode codes, links given different values
    task t_modes;
        for (int m = 0; m < 16; m++) begin
            apb(1, DLC_IDX_MODE_L1, 32'(m));
            apb(1, DLC_IDX_MODE_L2, 32'(15 - m));
            repeat (3) @(posedge clk_i);
            chk("cfg1", ecfg(4'(m)), link1_cfg_o);
            chk("cfg2", ecfg(4'(15 - m)), link2_cfg_o);
            apb(0, DLC_IDX_MODE_L1, 0);
            chk("mode_rd", 32'(m), rd);
        end
    endtask
    task t_mon;
        for (int c = 0; c < 4; c++) begin
            apb(1, DLC_IDX_MONITOR, {28'h0, c[1], 2'h0, c[0]});
            repeat (3) @(posedge clk_i);
            chk("path", c[0] ? (c[1] ? 3'h4 : 3'h2) : 3'h1, monitor_path_o);
        end
    endtask
    task t_swrst;
        int i;
        i = 0;
        apb(1, DLC_IDX_MODE_L1, 32'h7);
        apb(1, DLC_IDX_MONITOR, 32'h9);
        osc_present_i <= 0;
        apb(1, DLC_IDX_SW_RESET, 32'h5a);
        repeat (4) @(posedge clk_i);
        apb(0, DLC_IDX_MONITOR, 0);
        chk("no_osc", 32'h9, rd);
        osc_present_i <= 1;
        apb(1, DLC_IDX_SW_RESET, 0);
        while (sw_reset_o !== 1'b1 && i < 10) begin
            @(posedge clk_i);
            i++;
        end
        chk("pulse", 1, sw_reset_o);
        if (i >= 10) finish_test;
        repeat (3) @(posedge clk_i);
        apb(0, DLC_IDX_MONITOR, 0);
        chk("mon_clr", 0, rd);
        apb(0, DLC_IDX_MODE_L1, 0);
        chk("mode_kept", 32'h7, rd);
        chk("cfg_kept", ecfg(4'h7), link1_cfg_o);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        t_reset;
        t_modes;
        t_mon;
        t_swrst;
        t_hwrst;
        finish_test;
    end
endmodule // tb_dlc_global_cfg
`default_nettype wire
